// >>> tb/recloser_status_indications_props.sv
// Purpose: Concurrent checks on the recloser indication ports.
// Assumes: One clock domain; i_rstn low disables every check.
// Notes:   Bound to the design from the testbench top file.
`timescale 1ns/1ps
module recloser_checker
	import recloser_ind_pkg::*;
(
	input wire logic         i_core_clk,
	input wire logic         i_rstn,
	input wire logic         i_ce,
	input wire logic         i_external_enable_select,
	input wire logic         i_external_on_off,
	input wire logic         i_critical_request,
	input wire mode_e        i_mode,
	input wire phase_e       i_phase,
	input wire shot_t        i_shot,
	input wire logic         o_start_allowed,
	input wire indications_s o_ind
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn);
	property p_off; i_ce && i_external_enable_select && !i_external_on_off |=> o_ind.recloser_disabled_ind; endproperty
	a_off: assert property (p_off) else $error("disabled indication missing");
	property p_run; i_ce && i_mode == MODE_RUNNING |=> o_ind.running_mode_ind || o_ind.locked_mode_ind; endproperty
	a_run: assert property (p_run) else $error("running indication missing");
	property p_shot; $past(i_ce) && o_ind.running_mode_ind && $past(i_shot) inside {[1:5]}
		|-> o_ind.shot_active_ind == 5'h01 << ($past(i_shot) - 1); endproperty
	a_shot: assert property (p_shot) else $error("shot indication wrong");
	property p_arc; i_ce && i_phase == PHASE_ARCING |=> o_ind.arcing_interval_ind; endproperty
	a_arc: assert property (p_arc) else $error("arcing indication missing");
	property p_recl; i_ce && i_phase == PHASE_RECLAIM |=> o_ind.reclaim_interval_ind; endproperty
	a_recl: assert property (p_recl) else $error("reclaim indication missing");
	property p_lko; o_ind.lockout_after_success_ind |-> o_ind.locked_mode_ind && !o_start_allowed; endproperty
	a_lko: assert property (p_lko) else $error("lockout allowed a start");
	property p_crit; i_ce && i_critical_request |=> o_ind.locked_mode_ind [*2]; endproperty
	a_crit: assert property (p_crit) else $error("critical request did not lock");
	property p_mode; $onehot0({o_ind.ready_mode_ind, o_ind.running_mode_ind, o_ind.inhibit_mode_ind,
		o_ind.locked_mode_ind}); endproperty
	a_mode: assert property (p_mode) else $error("two mode indications");
	property p_one; $onehot0(o_ind.shot_active_ind) && $onehot0(o_ind.request_active_ind); endproperty
	a_one: assert property (p_one) else $error("two shot or request indications");
endmodule

// >>> tb/seq_model.sv
// Purpose: Sequencer and breaker control model facing the indication block.
// Assumes: Start is sampled on the rising edge.
// Notes:   Each phase lasts only a cycle or few, so whole sequences stay short.
`timescale 1ns/1ps
module seq_model
	import recloser_ind_pkg::*;
(
	input  wire logic i_clk,
	input  wire logic i_rstn,
	input  wire logic i_start,
	input  wire shot_t i_shot_sel,
	input  wire mode_e i_idle_mode,
	input  wire phase_e i_idle_phase,
	output mode_e     o_mode,
	output phase_e    o_phase,
	output shot_t     o_shot,
	output logic      o_opened
);
	logic [3:0] step_r;
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			step_r <= 4'h0;
		else if (step_r != 4'h0)
			step_r <= (step_r == 4'h8) ? 4'h0 : step_r + 4'h1;
		else if (i_start)
			step_r <= 4'h1;
	end
	always_comb begin
		o_mode   = (step_r != 4'h0) ? MODE_RUNNING : i_idle_mode;
		o_shot   = (step_r != 4'h0) ? i_shot_sel : SHOT_NONE;
		o_opened = step_r inside {[1:3]};
		o_phase  = (step_r == 4'h0) ? i_idle_phase : (step_r < 4'h4) ? PHASE_DEAD :
			(step_r < 4'h6) ? PHASE_ARCING : (step_r < 4'h8) ? PHASE_RECLAIM : PHASE_FINISHED;
	end
endmodule

// >>> tb/tb.sv
// Purpose: Self-checking bench for the recloser indication block.
// Assumes: Inputs change on the falling edge; outputs are read there too.
// Notes:   Indication bit positions in wait_on follow the struct packing order.
`timescale 1ns/1ps
module tb;
	import recloser_ind_pkg::*;
	logic clk = 0, rstn = 0, ce = 1, fen = 1, esel = 0, eon = 0, crit = 0, lck = 0;
	logic mrst = 0, flt = 0, ftd = 0, start = 0, opened, allowed;
	request_s req = '0;
	mode_e imode = MODE_READY, mode;
	phase_e iphase = PHASE_IDLE, phase;
	shot_t shot, ssel = 3'h3;
	indications_s ind;
	int bad_count = 0, checks_done = 0;
	always #12.5 clk = ~clk;
	seq_model SEQ (.i_clk(clk), .i_rstn(rstn), .i_start(start), .i_shot_sel(ssel), .i_idle_mode(imode),
		.i_idle_phase(iphase), .o_mode(mode), .o_phase(phase), .o_shot(shot), .o_opened(opened));
	recloser_status_indications DUT (.i_core_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_function_enable(fen),
		.i_external_enable_select(esel), .i_external_on_off(eon), .i_critical_request(crit), .i_locking(lck),
		.i_manual_reset(mrst), .i_fault(flt), .i_breaker_opened_by_ar(opened), .i_final_trip_done(ftd),
		.i_req(req), .i_mode(mode), .i_phase(phase), .i_shot(shot), .o_start_allowed(allowed), .o_ind(ind));
	task chk(input string n, input logic [4:0] e, input logic [4:0] g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task tick(input int n); repeat (n) @(negedge clk); endtask
	task conclude;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task wait_on(input int pos);
		for (int i = 0; i < 20; i++) begin
			if (ind[pos] === 1'b1) return;
			tick(1);
		end
		chk("wait", 1, 0);
		conclude();
	endtask
	task unlock;
		mrst = 1;
		tick(1);
		mrst = 0;
		tick(2);
		chk("ready", 1, ind.ready_mode_ind);
	endtask
	task t_enable;
		for (int k = 0; k < 4; k++) begin
			{esel, eon} = k[1:0];
			tick(2);
			chk("enabled", !(esel && !eon), ind.recloser_enabled_ind);
			chk("disabled", esel && !eon, ind.recloser_disabled_ind);
		end
		esel = 0;
		$display("enable test done");
	endtask
	task t_ce;
		ce = 0;
		esel = 1;
		eon = 0;
		tick(2);
		chk("frozen enabled", 1, ind.recloser_enabled_ind);
		chk("frozen disabled", 0, ind.recloser_disabled_ind);
		ce = 1;
		tick(1);
		chk("thawed disabled", 1, ind.recloser_disabled_ind);
		esel = 0;
		tick(1);
		$display("clock enable test done");
	endtask
	task t_seq(input shot_t s, input logic [4:0] r, input logic [4:0] er);
		ssel = s;
		req = request_s'(r);
		start = 1;
		tick(1);
		start = 0;
		wait_on(16);
		chk("running", 1, ind.running_mode_ind);
		chk("pending", 1, ind.reclose_pending_ind);
		chk("shot", 5'h01 << (s - 3'h1), ind.shot_active_ind);
		chk("request", er, ind.request_active_ind);
		req = request_s'(r | 5'h01);
		tick(1);
		chk("override", 5'h01, ind.request_active_ind);
		wait_on(15);
		wait_on(14);
		wait_on(18);
		req = '0;
		tick(3);
		chk("ready", 1, ind.ready_mode_ind);
		chk("idle shot", 5'h00, ind.shot_active_ind);
		$display("sequence test done");
	endtask
	task t_lock(input bit c);
		if (c) crit = 1;
		else lck = 1;
		tick(c ? 1 : 2);
		chk("locked", 1, ind.locked_mode_ind);
		crit = 0;
		lck = 0;
		tick(2);
		chk("held", 1, ind.locked_mode_ind);
		unlock();
		$display("lock test done");
	endtask
	task t_lockout;
		iphase = PHASE_LOCKOUT_DELAY;
		flt = 1;
		tick(1);
		flt = 0;
		iphase = PHASE_IDLE;
		tick(2);
		chk("lockout", 1, ind.lockout_after_success_ind);
		chk("start allowed", 0, allowed);
		unlock();
		chk("lockout clear", 0, ind.lockout_after_success_ind);
		$display("lockout test done");
	endtask
	task t_final;
		imode = MODE_INHIBIT;
		ftd = 1;
		tick(1);
		ftd = 0;
		tick(1);
		chk("final trip", 1, ind.final_trip_ind);
		chk("inhibit", 1, ind.inhibit_mode_ind);
		imode = MODE_READY;
		tick(2);
		chk("final trip clear", 0, ind.final_trip_ind);
		$display("final trip test done");
	endtask
	task t_reset;
		crit = 1;
		tick(1);
		chk("locked before reset", 1, ind.locked_mode_ind);
		crit = 0;
		rstn = 0;
		tick(1);
		chk("locked in reset", 0, ind.locked_mode_ind);
		chk("ready in reset", 0, ind.ready_mode_ind);
		rstn = 1;
		tick(2);
		chk("ready after reset", 1, ind.ready_mode_ind);
		chk("locked after reset", 0, ind.locked_mode_ind);
		$display("reset test done");
	endtask
	initial begin
		repeat (2) @(posedge clk);
		@(negedge clk) rstn = 1;
		tick(1);
		t_enable();
		t_ce();
		t_seq(3'h3, 5'h0a, 5'h02);
		t_seq(3'h5, 5'h10, 5'h10);
		t_lock(1);
		t_lock(0);
		t_lockout();
		t_final();
		t_reset();
		conclude();
	end
endmodule
bind recloser_status_indications recloser_checker u_chk (.i_core_clk, .i_rstn, .i_ce, .i_external_enable_select,
	.i_external_on_off, .i_critical_request, .i_mode, .i_phase, .i_shot, .o_start_allowed, .o_ind);

// >>> verilog/lockout_tracker.sv
// Purpose: Tracks the post-success lockout condition.
// Assumes: Phase and fault inputs synchronous to the core clock.
// Notes:   Cleared only by manual reset.
`timescale 1ns/1ps
module lockout_tracker (
	input  wire logic                     i_core_clk,
	input  wire logic                     i_rstn,
	input  wire logic                     i_ce,
	input  wire recloser_ind_pkg::phase_e i_phase,
	input  wire logic                     i_fault,
	input  wire logic                     i_manual_reset,
	output logic                          o_lockout
);
	import recloser_ind_pkg::*;

	logic lockout_r;
	logic lockout_nxt;

	// A fault during the lock-out delay after a good sequence latches the lockout.
	// The set wins over a simultaneous manual reset so the event is not lost.
	always_comb begin
		lockout_nxt = lockout_r;
		if (i_manual_reset) begin
			lockout_nxt = 1'b0;
		end
		if (i_phase == PHASE_LOCKOUT_DELAY && i_fault) begin
			lockout_nxt = 1'b1;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			lockout_r <= IND_RESET;
		end else if (i_ce) begin
			lockout_r <= lockout_nxt;
		end
	end

	assign o_lockout = lockout_r;

endmodule

// >>> verilog/recloser_ind_pkg.sv
// Purpose: Shared types and constants for the recloser indication block.
// Assumes: One 40 MHz clock, asynchronous active-low reset.
// Notes:   Indications are level outputs, all registered.
package recloser_ind_pkg;

	localparam int unsigned REQ_COUNT  = 5;
	localparam int unsigned SHOT_COUNT = 5;

	// Mode of the recloser, held by the surrounding sequencer.
	typedef enum logic [1:0] {
		MODE_READY,
		MODE_RUNNING,
		MODE_INHIBIT,
		MODE_LOCKED
	} mode_e;

	// Timer phase reported by the sequencer.
	typedef enum logic [2:0] {
		PHASE_IDLE,
		PHASE_DEAD,
		PHASE_ARCING,
		PHASE_RECLAIM,
		PHASE_FINISHED,
		PHASE_LOCKOUT_DELAY
	} phase_e;

	typedef logic [2:0] shot_t;

	localparam shot_t SHOT_NONE = 3'h0;
	localparam logic [4:0] ONEHOT_RESET = 5'h00;
	localparam logic       IND_RESET    = 1'b0;

	// Request inputs, index 0 is the first and highest priority.
	typedef struct packed {
		logic reclose_request_fifth;
		logic reclose_request_fourth;
		logic reclose_request_third;
		logic reclose_request_second;
		logic reclose_request_first;
	} request_s;

	// Indication outputs of the recloser.
	typedef struct packed {
		logic       recloser_enabled_ind;
		logic       recloser_disabled_ind;
		logic       reclose_pending_ind;
		logic       running_mode_ind;
		logic       sequence_done_ind;
		logic       final_trip_ind;
		logic       dead_interval_ind;
		logic       arcing_interval_ind;
		logic       reclaim_interval_ind;
		logic       ready_mode_ind;
		logic       lockout_after_success_ind;
		logic       inhibit_mode_ind;
		logic       locked_mode_ind;
		logic [4:0] request_active_ind;
		logic [4:0] shot_active_ind;
	} indications_s;

	localparam indications_s IND_ALL_RESET = '0;

	// Turns a shot number 1..5 into a one-hot vector; zero or out of range gives none.
	function automatic logic [4:0] shot_onehot(input shot_t shot);
		logic [4:0] v;
		v = ONEHOT_RESET;
		if (shot >= 3'h1 && shot <= 3'h5) begin
			v[shot - 3'h1] = 1'b1;
		end
		return v;
	endfunction

endpackage

// >>> verilog/recloser_status_indications.sv
// Purpose: Indication outputs of a feeder auto-reclosing function.
// Assumes: Mode, phase and shot number come from the recloser sequencer on the same clock.
// Notes:   Drives no breaker command; o_ind is registered, o_start_allowed is an AND of registered bits.
`timescale 1ns/1ps
module recloser_status_indications (
	input  wire logic                      i_core_clk,
	input  wire logic                      i_rstn,
	input  wire logic                      i_ce,
	input  wire logic                      i_function_enable,
	input  wire logic                      i_external_enable_select,
	input  wire logic                      i_external_on_off,
	input  wire logic                      i_critical_request,
	input  wire logic                      i_locking,
	input  wire logic                      i_manual_reset,
	input  wire logic                      i_fault,
	input  wire logic                      i_breaker_opened_by_ar,
	input  wire logic                      i_final_trip_done,
	input  wire recloser_ind_pkg::request_s i_req,
	input  wire recloser_ind_pkg::mode_e   i_mode,
	input  wire recloser_ind_pkg::phase_e  i_phase,
	input  wire recloser_ind_pkg::shot_t   i_shot,
	output logic                           o_start_allowed,
	output recloser_ind_pkg::indications_s o_ind
);
	import recloser_ind_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Request priority and post-success lockout.

	logic [4:0] grant;
	logic       lockout;

	request_priority u_prio (
		.i_req   (i_req),
		.o_grant (grant)
	);

	lockout_tracker u_lock (
		.i_core_clk     (i_core_clk),
		.i_rstn         (i_rstn),
		.i_ce           (i_ce),
		.i_phase        (i_phase),
		.i_fault        (i_fault),
		.i_manual_reset (i_manual_reset),
		.o_lockout      (lockout)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Latched lock causes and the highest request granted during the current shot.

	logic       hold_lock_r;
	logic       hold_lock_nxt;
	logic [4:0] shot_req_r;
	logic [4:0] shot_req_nxt;
	logic       final_trip_r;
	logic       final_trip_nxt;

	// Locking and critical requests stay latched until a manual reset.
	// Set beats clear so a request in the reset cycle still locks.
	always_comb begin
		hold_lock_nxt = hold_lock_r;
		if (i_manual_reset) begin
			hold_lock_nxt = 1'b0;
		end
		if (i_locking || i_critical_request) begin
			hold_lock_nxt = 1'b1;
		end
	end

	// The winning request is captured when a shot starts and held until the shot ends,
	// but a later higher request replaces it while the shot is under way.
	always_comb begin
		shot_req_nxt = shot_req_r;
		if (i_mode != MODE_RUNNING || i_shot == SHOT_NONE) begin
			shot_req_nxt = ONEHOT_RESET;
		end else if (shot_req_r == ONEHOT_RESET || grant < shot_req_r && grant != ONEHOT_RESET) begin
			shot_req_nxt = grant;
		end
	end

	// Final trip stays shown until the function is re-armed.
	always_comb begin
		final_trip_nxt = final_trip_r;
		if (i_manual_reset || i_mode == MODE_READY) begin
			final_trip_nxt = 1'b0;
		end
		if (i_final_trip_done) begin
			final_trip_nxt = 1'b1;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			hold_lock_r  <= IND_RESET;
			shot_req_r   <= ONEHOT_RESET;
			final_trip_r <= IND_RESET;
		end else if (i_ce) begin
			hold_lock_r  <= hold_lock_nxt;
			shot_req_r   <= shot_req_nxt;
			final_trip_r <= final_trip_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Effective mode: any lock cause overrides the sequencer's own mode.

	mode_e eff_mode;

	always_comb begin
		eff_mode = i_mode;
		if (i_critical_request || hold_lock_r || lockout) begin
			eff_mode = MODE_LOCKED;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Indication registers.

	indications_s ind_r;
	indications_s ind_nxt;
	logic         enabled;

	always_comb begin
		enabled = i_function_enable && (!i_external_enable_select || i_external_on_off);
		ind_nxt = IND_ALL_RESET;
		ind_nxt.recloser_enabled_ind  = enabled;
		ind_nxt.recloser_disabled_ind = i_external_enable_select && !i_external_on_off;
		// One decoded mode keeps these four exclusive.
		ind_nxt.ready_mode_ind   = eff_mode == MODE_READY && enabled;
		ind_nxt.running_mode_ind = eff_mode == MODE_RUNNING;
		ind_nxt.inhibit_mode_ind = eff_mode == MODE_INHIBIT || (eff_mode == MODE_READY && !enabled);
		ind_nxt.locked_mode_ind  = eff_mode == MODE_LOCKED;
		if (eff_mode == MODE_RUNNING) begin
			ind_nxt.dead_interval_ind   = i_phase == PHASE_DEAD && i_breaker_opened_by_ar;
			ind_nxt.reclose_pending_ind = i_phase == PHASE_DEAD && i_breaker_opened_by_ar;
			ind_nxt.arcing_interval_ind = i_phase == PHASE_ARCING;
			ind_nxt.sequence_done_ind   = i_phase == PHASE_FINISHED;
			// One-hot shot and captured request keep at most one of each.
			ind_nxt.shot_active_ind     = shot_onehot(i_shot);
			ind_nxt.request_active_ind  = shot_req_nxt;
		end
		ind_nxt.reclaim_interval_ind = i_phase == PHASE_RECLAIM || i_phase == PHASE_FINISHED;
		ind_nxt.final_trip_ind       = final_trip_nxt;
		ind_nxt.lockout_after_success_ind = lockout;
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ind_r <= IND_ALL_RESET;
		end else if (i_ce) begin
			ind_r <= ind_nxt;
		end
	end

	// Indications and the start permission leave the block; there is no breaker command port.
	assign o_ind = ind_r;

	// The sequencer must not start while locked out or not ready.
	assign o_start_allowed = ind_r.ready_mode_ind && !lockout;

endmodule

// >>> verilog/request_priority.sv
// Purpose: Picks the highest-priority active reclose request.
// Assumes: Requests are synchronous to the core clock.
// Notes:   Purely combinational one-hot result.
`timescale 1ns/1ps
module request_priority (
	input  wire recloser_ind_pkg::request_s i_req,
	output logic [4:0]                      o_grant
);
	import recloser_ind_pkg::*;

	logic [4:0] req_vec;

	assign req_vec = i_req;

	// The first request beats every lower one.
	always_comb begin
		o_grant = ONEHOT_RESET;
		if (req_vec[0]) begin
			o_grant[0] = 1'b1;
		end else if (req_vec[1]) begin
			o_grant[1] = 1'b1;
		end else if (req_vec[2]) begin
			o_grant[2] = 1'b1;
		end else if (req_vec[3]) begin
			o_grant[3] = 1'b1;
		end else if (req_vec[4]) begin
			o_grant[4] = 1'b1;
		end
	end

endmodule
